// File: hdl/pll_ctl_pkg.sv
package pll_ctl_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_CTRL      = 6'h00;
  localparam logic [5:0] IDX_PUMP      = 6'h01;
  localparam logic [5:0] IDX_FILTER    = 6'h04;
  localparam logic [5:0] IDX_DPA_RES   = 6'h05;
  localparam logic [5:0] IDX_CLK_DIV   = 6'h06;
  localparam logic [5:0] IDX_REF       = 6'h07;
  localparam logic [5:0] IDX_SWRST     = 6'h08;
  localparam logic [5:0] IDX_STATE     = 6'h09;
  localparam logic [5:0] IDX_STATUS    = 6'h12;
  localparam int         ADDR_W        = 8;
  localparam int         DATA_W        = 32;
  // Field positions
  localparam int CTRL_FORCE_BIT  = 0;
  localparam int CTRL_POL_BIT    = 1;
  localparam int CTRL_SPOL_BIT   = 2;
  localparam int CTRL_SRC_LSB    = 6;
  localparam int PUMP_ICP_LSB    = 0;
  localparam int PUMP_VCO_LSB    = 4;
  localparam int FILT_SEL_BIT    = 7;
  localparam int FILT_OFS_LSB    = 0;
  localparam int CLKDIV_LSB      = 6;
  localparam int REF_SEL_BIT     = 7;
  localparam int REF_DIV_LSB     = 0;
  localparam int STATUS_LOCK_BIT = 1;
  // Reset values
  localparam logic [7:0] CTRL_RST    = 8'h01;
  localparam logic [7:0] PUMP_RST    = 8'h03;
  localparam logic [7:0] FILTER_RST  = 8'h00;
  localparam logic [1:0] DPA_RES_RST = 2'h0;
  localparam logic [7:0] CLKDIV_RST  = 8'h00;
  localparam logic [7:0] REF_RST     = 8'h01;
  // Codes
  localparam logic [3:0] SWRST_KEY     = 4'ha;
  localparam logic [1:0] SRC_LOW       = 2'h0;
  localparam logic [1:0] SRC_LOCK      = 2'h1;
  localparam logic [1:0] SRC_REF       = 2'h3;
  localparam logic [1:0] RES_16        = 2'h0;
  localparam logic [1:0] RES_32        = 2'h1;
  localparam logic [1:0] RES_64        = 2'h3;
  localparam logic [2:0] ICP_RESERVED  = 3'h7;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  localparam logic [1:0] REARM_EDGES   = 2'h2;
  localparam int         REF_DIV_W     = 7;
endpackage : pll_ctl_pkg

// File: hdl/sync_ctl_if.sv
`timescale 1ns/100ps
interface sync_ctl_if;
  import pll_ctl_pkg::*;
  logic                 force_on;
  logic                 polarity;
  logic                 hold_raw;
  logic                 hold_sync;
  logic                 hsync_rise;
  logic                 pump_on;
  logic [REF_DIV_W-1:0] ref_div;
  logic                 osc_rise;
  logic                 ref_level;
  modport ctrl (output force_on, polarity, hold_raw, hold_sync, hsync_rise, ref_div, osc_rise,
                input pump_on, ref_level);
  modport pump (input force_on, polarity, hold_raw, hold_sync, hsync_rise, output pump_on);
  modport refg (input ref_div, osc_rise, output ref_level);
endinterface : sync_ctl_if

// File: hdl/ref_generator.sv
`timescale 1ns/100ps
module ref_generator
  import pll_ctl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control side
  sync_ctl_if.refg rg
);

  logic [REF_DIV_W-1:0] low_left;

  // One oscillator period high, then N+1 low, back to back with no gap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rg.ref_level <= 1'b1;
      low_left     <= '0;
    end else if (rg.osc_rise) begin
      if (rg.ref_level) begin
        rg.ref_level <= 1'b0;
        low_left     <= rg.ref_div;
      end else if (low_left == '0) begin
        rg.ref_level <= 1'b1;
      end else begin
        low_left <= low_left - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_high_start;
    rg.osc_rise && !rg.ref_level && low_left == '0;
  endsequence

  // High phase ends on the very next oscillator rise, so it spans one period
  sequence s_high_end;
    rg.osc_rise && rg.ref_level;
  endsequence

  chk_ref_high_one: assert property (@(posedge aclk) disable iff (!aresetn)
    s_high_end |=> !rg.ref_level)
    else $error("reference high longer than one oscillator period");

  chk_ref_no_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    s_high_start |=> rg.ref_level)
    else $error("reference did not restart its high phase");

  chk_ref_low_load: assert property (@(posedge aclk) disable iff (!aresetn)
    rg.osc_rise && rg.ref_level |=> low_left == $past(rg.ref_div))
    else $error("low phase not loaded from divider field");

endmodule : ref_generator

// File: hdl/pump_gate.sv
`timescale 1ns/100ps
module pump_gate
  import pll_ctl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control side
  sync_ctl_if.pump pg
);

  logic       armed;
  logic [1:0] edges;
  logic       cond_raw;
  logic       cond_sync;

  assign cond_raw  = pg.force_on | (pg.hold_raw == ~pg.polarity);
  assign cond_sync = pg.force_on | (pg.hold_sync == ~pg.polarity);

  // Re-arm only after the second sync edge once the hold condition is gone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed <= 1'b1;
      edges <= '0;
    end else if (!cond_sync) begin
      armed <= 1'b0;
      edges <= '0;
    end else if (!armed && pg.hsync_rise) begin
      if (edges + 2'h1 == REARM_EDGES) begin
        armed <= 1'b1;
      end
      edges <= edges + 2'h1;
    end
  end

  // The raw pin cuts the pump with no clock in the path; re-enable is clocked
  assign pg.pump_on = pg.force_on | (armed & cond_raw);

  ////////////////////////////////////////////////////////////////////////////
  chk_pump_off_now: assert property (@(posedge aclk) disable iff (!aresetn)
    !cond_raw |-> !pg.pump_on)
    else $error("pump not cut at once by hold input");

  chk_pump_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    pg.force_on |-> pg.pump_on)
    else $error("pump not on while forced");

  sequence s_released;
    !armed && cond_sync && pg.hsync_rise && edges == '0;
  endsequence

  chk_rearm_second: assert property (@(posedge aclk) disable iff (!aresetn)
    s_released |=> !armed)
    else $error("pump re-armed on first sync edge");

endmodule : pump_gate

// File: hdl/pll_sync_ref_control.sv
`timescale 1ns/100ps
// Summary of operation
// - Force bit or polarity-matched hold enables pump
// - Hold cuts pump instantly; second sync re-arms
// - Source 00 drives low, 01 drives lock
// - Source 11: reference or polarity-adjusted sync
// - Clock divider field selects 1, 2, 4, 8
// - Pump current codes 0 to 6 select power-of-two microamps; code 7 gives zero
// - VCO divider field selects 2, 4, 8, 16
// - Resolution selects 16, 32, 64 elements
// - Resolution shadowed until reset key written
// - Reference high one period, low N+1
// - Select bit feeds reference to phase detector
// - Filter bit selects internal or external filter
module pll_sync_ref_control
  import pll_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Pins
  input  wire logic              osc_in,
  input  wire logic              hsync_in,
  input  wire logic              pump_hold_input,
  input  wire logic              pll_locked_in,
  // Analog control
  output logic                   pump_enable,
  output logic                   lockref_out,
  output logic                   phase_detect_in,
  output logic                   loop_filter_internal,
  output logic [6:0]             pump_current_ua,
  output logic [4:0]             vco_divide,
  output logic [3:0]             clk_divide,
  output logic [6:0]             dpa_elements,
  output logic [5:0]             phase_offset_value,
  output logic [1:0]             dpa_res_working
);

  // Power-of-two factor from a two-bit code
  function automatic logic [4:0] pow2(input logic [1:0] code);
    pow2 = 5'h01 << code;
  endfunction : pow2

  // Largest offset allowed for a resolution code; reserved maps to zero
  function automatic logic [5:0] max_offset(input logic [1:0] res);
    case (res)
      RES_16:  max_offset = 6'h0f;
      RES_32:  max_offset = 6'h1f;
      RES_64:  max_offset = 6'h3f;
      default: max_offset = 6'h00;
    endcase
  endfunction : max_offset

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, then edge detection on the second stage only
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] sync_ff1;
  logic [NSYNC-1:0] sync_ff2;
  logic             osc_prev;
  logic             hsync_prev;
  logic             hsync_s;
  logic             locked_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_ff1 <= '0;
      sync_ff2 <= '0;
    end else begin
      sync_ff1 <= {pll_locked_in, pump_hold_input, hsync_in, osc_in};
      sync_ff2 <= sync_ff1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_prev   <= 1'b0;
      hsync_prev <= 1'b0;
    end else begin
      osc_prev   <= sync_ff2[0];
      hsync_prev <= sync_ff2[1];
    end
  end

  assign hsync_s  = sync_ff2[1];
  assign locked_s = sync_ff2[3];

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] reg_ctrl;
  logic [7:0] reg_pump;
  logic [7:0] reg_filter;
  logic [1:0] res_shadow;
  logic [7:0] reg_clkdiv;
  logic [7:0] reg_ref;

  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0]        w_data_q;
  logic              w_lane0_q;
  logic              do_write;
  logic [5:0]        w_idx;
  logic              swrst_hit;

  assign awready  = !aw_held;
  assign wready   = !w_held;
  assign do_write = aw_held && w_held && !bvalid;
  assign w_idx    = aw_addr_q[ADDR_W-1:2];
  assign swrst_hit = do_write && w_lane0_q && w_idx == IDX_SWRST && w_data_q[3:0] == SWRST_KEY;

  // Address and data are taken in either order and held until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_lane0_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held    <= 1'b1;
        w_data_q  <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  function automatic logic mapped(input logic [5:0] idx, input logic wr);
    case (idx)
      IDX_CTRL, IDX_PUMP, IDX_FILTER, IDX_DPA_RES, IDX_CLK_DIV, IDX_REF: mapped = 1'b1;
      IDX_SWRST:              mapped = wr;
      IDX_STATE, IDX_STATUS:  mapped = !wr;
      default:                mapped = 1'b0;
    endcase
  endfunction : mapped

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= mapped(w_idx, 1'b1) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_ctrl   <= CTRL_RST;
      reg_pump   <= PUMP_RST;
      reg_filter <= FILTER_RST;
      res_shadow <= DPA_RES_RST;
      reg_clkdiv <= CLKDIV_RST;
      reg_ref    <= REF_RST;
    end else if (do_write && w_lane0_q) begin
      case (w_idx)
        IDX_CTRL:    reg_ctrl   <= w_data_q;
        IDX_PUMP:    reg_pump   <= w_data_q;
        IDX_FILTER:  reg_filter <= w_data_q;
        IDX_DPA_RES: res_shadow <= w_data_q[1:0];
        IDX_CLK_DIV: reg_clkdiv <= w_data_q;
        IDX_REF:     reg_ref    <= w_data_q;
        default:     ;
      endcase
    end
  end

  // Working resolution moves only on the software reset key
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dpa_res_working <= DPA_RES_RST;
    end else if (swrst_hit) begin
      dpa_res_working <= res_shadow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pump gate and reference generator
  sync_ctl_if sc ();

  assign sc.force_on   = reg_ctrl[CTRL_FORCE_BIT];
  assign sc.polarity   = reg_ctrl[CTRL_POL_BIT];
  assign sc.hold_raw   = pump_hold_input;
  assign sc.hold_sync  = sync_ff2[2];
  assign sc.hsync_rise = hsync_s && !hsync_prev;
  assign sc.osc_rise   = sync_ff2[0] && !osc_prev;
  assign sc.ref_div    = reg_ref[REF_DIV_LSB +: REF_DIV_W];
  assign pump_enable   = sc.pump_on;

  pump_gate u_pump (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pg      (sc.pump)
  );

  ref_generator u_ref (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rg      (sc.refg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read port, one cycle after the address is taken
  logic [7:0] rd_val;

  always_comb begin
    rd_val = 8'h00;
    case (araddr[ADDR_W-1:2])
      IDX_CTRL:    rd_val = reg_ctrl;
      IDX_PUMP:    rd_val = reg_pump;
      IDX_FILTER:  rd_val = reg_filter;
      IDX_DPA_RES: rd_val = {6'h00, res_shadow};
      IDX_CLK_DIV: rd_val = reg_clkdiv;
      IDX_REF:     rd_val = reg_ref;
      IDX_STATE:   rd_val = {4'h0, sc.ref_level, sc.pump_on, dpa_res_working};
      IDX_STATUS:  rd_val = 8'(locked_s) << STATUS_LOCK_BIT;
      default:     rd_val = 8'h00;
    endcase
  end

  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, rd_val};
      rresp  <= mapped(araddr[ADDR_W-1:2], 1'b0) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded analog controls, registered
  logic [1:0] src_sel;
  logic       ref_sel;
  logic [2:0] icp_code;
  logic [5:0] ofs_req;

  assign src_sel  = reg_ctrl[CTRL_SRC_LSB +: 2];
  assign ref_sel  = reg_ref[REF_SEL_BIT];
  assign icp_code = reg_pump[PUMP_ICP_LSB +: 3];
  assign ofs_req  = reg_filter[FILT_OFS_LSB +: 6];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lockref_out <= 1'b0;
    end else begin
      case (src_sel)
        SRC_LOW:  lockref_out <= 1'b0;
        SRC_LOCK: lockref_out <= locked_s;
        SRC_REF:  lockref_out <= ref_sel ? sc.ref_level
                                         : hsync_s ^ reg_ctrl[CTRL_SPOL_BIT];
        default:  lockref_out <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_detect_in <= 1'b0;
    end else begin
      phase_detect_in <= ref_sel ? sc.ref_level : hsync_s;
    end
  end

  // Offsets above the working maximum are clipped, so a stray write cannot overrun
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_filter_internal <= 1'b0;
      pump_current_ua      <= '0;
      vco_divide           <= '0;
      clk_divide           <= '0;
      dpa_elements         <= '0;
      phase_offset_value   <= '0;
    end else begin
      loop_filter_internal <= reg_filter[FILT_SEL_BIT];
      pump_current_ua      <= (icp_code == ICP_RESERVED) ? 7'h00 : 7'h01 << icp_code;
      vco_divide           <= pow2(reg_pump[PUMP_VCO_LSB +: 2]) << 1;
      clk_divide           <= 4'(pow2(reg_clkdiv[CLKDIV_LSB +: 2]));
      dpa_elements         <= 7'(max_offset(dpa_res_working)) + 7'h01;
      phase_offset_value   <= (ofs_req > max_offset(dpa_res_working))
                              ? max_offset(dpa_res_working) : ofs_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_key_write;
    swrst_hit;
  endsequence

  chk_res_transfer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_key_write |=> dpa_res_working == $past(res_shadow))
    else $error("resolution not transferred on reset key");

  chk_res_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !swrst_hit |=> $stable(dpa_res_working))
    else $error("working resolution moved without reset key");

  chk_lockref_src: assert property (@(posedge aclk) disable iff (!aresetn)
    src_sel == SRC_LOW ##1 src_sel == SRC_LOW |-> !lockref_out)
    else $error("lock output not low for source 00");

  chk_detect_ref: assert property (@(posedge aclk) disable iff (!aresetn)
    ref_sel |=> phase_detect_in == $past(sc.ref_level))
    else $error("phase detector not fed from reference");

  chk_clk_divide: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_clkdiv[CLKDIV_LSB +: 2] == 2'h3 |=> clk_divide == 4'h8)
    else $error("clock divide code 11 not eight");

  chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> bvalid)
    else $error("write response missing");

endmodule : pll_sync_ref_control

// File: test/sync_source_model.sv
`timescale 1ns/100ps
module sync_source_model #(
  parameter int OSC_HALF = 4
) (
  // Clock
  input  wire logic aclk,
  // Requests from the bench
  input  wire logic hs_pulse,
  input  wire logic hs_level,
  // Pins toward the block
  output logic      osc_in,
  output logic      hsync_in
);
  int osc_cnt = 0;
  int hs_cnt  = 0;
  initial osc_in = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // A crystal runs free, so the oscillator never stops between tests
  always @(posedge aclk) begin
    osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == OSC_HALF - 1) osc_in <= ~osc_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Each sync pulse is wide enough to survive the two-flop synchronizer
  always @(posedge aclk) begin
    hs_cnt <= hs_pulse ? 4 : (hs_cnt > 0 ? hs_cnt - 1 : 0);
  end
  assign hsync_in = hs_level | (hs_cnt != 0);
endmodule : sync_source_model

// File: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import pll_ctl_pkg::*;
  localparam int OSC_HALF = 4;
  localparam int P        = 2 * OSC_HALF;
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata;
  logic [1:0]        bresp, rresp, dpa_res_working, last_resp, prev;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic              rready = 1'b0, hold_pin = 1'b1, lock_pin = 1'b0;
  logic              hs_pulse = 1'b0, hs_level = 1'b0, osc_in, hsync_in;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              pump_enable, lockref_out, phase_detect_in, loop_filter_internal;
  logic [6:0]        pump_current_ua, dpa_elements;
  logic [4:0]        vco_divide;
  logic [3:0]        clk_divide;
  logic [5:0]        phase_offset_value;
  logic [31:0]       last_data;
  int                fails = 0, tests_run = 0, i, hi, lo, hi2;
  logic [5:0] rst_idx [6] = '{IDX_CTRL, IDX_PUMP, IDX_FILTER, IDX_DPA_RES, IDX_CLK_DIV, IDX_REF};
  logic [7:0] rst_val [6] = '{CTRL_RST, PUMP_RST, FILTER_RST, 8'h00, CLKDIV_RST, REF_RST};
  logic [1:0] res_code [4] = '{RES_32, RES_64, 2'h2, RES_16};
  logic [6:0] res_elem [4] = '{7'h20, 7'h40, 7'h01, 7'h10};
  logic [5:0] res_clip [4] = '{6'h1f, 6'h3f, 6'h00, 6'h0f};
  initial forever #10 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  pll_sync_ref_control u_pll_sync_ref_control (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .osc_in(osc_in),
    .hsync_in(hsync_in), .pump_hold_input(hold_pin), .pll_locked_in(lock_pin),
    .pump_enable(pump_enable), .lockref_out(lockref_out), .phase_detect_in(phase_detect_in),
    .loop_filter_internal(loop_filter_internal), .pump_current_ua(pump_current_ua),
    .vco_divide(vco_divide), .clk_divide(clk_divide), .dpa_elements(dpa_elements),
    .phase_offset_value(phase_offset_value), .dpa_res_working(dpa_res_working));
  sync_source_model #(.OSC_HALF(OSC_HALF)) u_sync_source_model (
    .aclk(aclk), .hs_pulse(hs_pulse), .hs_level(hs_level), .osc_in(osc_in),
    .hsync_in(hsync_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic bound(input int n);
    if (n >= 400) begin
      fails++;
      summarize();
    end
  endtask : bound
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : settle
  // Address and data go out together; each is dropped once its own ready is seen
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    int n;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        last_resp = bresp;
        bready   <= 1'b0;
        break;
      end
    end
    bound(n);
  endtask : wr
  task automatic rd(input logic [5:0] idx);
    int n;
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        last_data = rdata;
        last_resp = rresp;
        rready   <= 1'b0;
        break;
      end
    end
    bound(n);
  endtask : rd
  task automatic pulse();
    @(posedge aclk);
    hs_pulse <= 1'b1;
    @(posedge aclk);
    hs_pulse <= 1'b0;
    settle(10);
  endtask : pulse
  function automatic logic sig(input bit pd);
    return pd ? phase_detect_in : lockref_out;
  endfunction : sig
  // Counts one whole high, the low after it and the next high, in clock cycles
  task automatic measure(input bit pd);
    int n;
    for (n = 0; n < 400 && sig(pd) !== 1'b0; n++) @(posedge aclk);
    bound(n);
    for (n = 0; n < 400 && sig(pd) !== 1'b1; n++) @(posedge aclk);
    bound(n);
    for (hi = 0; hi < 400 && sig(pd) === 1'b1; hi++) @(posedge aclk);
    for (lo = 0; lo < 400 && sig(pd) === 1'b0; lo++) @(posedge aclk);
    for (hi2 = 0; hi2 < 400 && sig(pd) === 1'b1; hi2++) @(posedge aclk);
    bound(hi2);
  endtask : measure
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      rd(rst_idx[i]);
      check("reset_value", last_data, {24'h0, rst_val[i]});
    end
    check("pump_enable", pump_enable, 32'h1);
    check("pump_current_ua", pump_current_ua, 32'h8);
    check("dpa_elements", dpa_elements, 32'h10);
    check("loop_filter_internal", loop_filter_internal, 32'h0);
    wr(6'h03, 8'hff);
    check("unmapped_bresp", last_resp, RESP_SLVERR);
    rd(6'h03);
    check("unmapped_rdata", last_data, 32'h0);
    check("unmapped_rresp", last_resp, RESP_SLVERR);
    for (i = 0; i < 4; i++) begin
      wr(IDX_CLK_DIV, 8'(i << CLKDIV_LSB));
      check("clkdiv_bresp", last_resp, RESP_OKAY);
      wr(IDX_PUMP, 8'((i << PUMP_VCO_LSB) | 3));
      settle(2);
      check("clk_divide", clk_divide, 32'(1 << i));
      check("vco_divide", vco_divide, 32'(2 << i));
    end
    for (i = 0; i < 8; i++) begin
      wr(IDX_PUMP, 8'(i));
      settle(2);
      check("pump_current_ua", pump_current_ua, (i == 7) ? 32'h0 : 32'(1 << i));
    end
    wr(IDX_FILTER, 8'hbf);
    settle(2);
    check("loop_filter_internal", loop_filter_internal, 32'h1);
    check("phase_offset_16", phase_offset_value, 32'h0f);
    // A wrong key must leave the working resolution alone
    wr(IDX_DPA_RES, 8'(RES_64));
    wr(IDX_SWRST, 8'h05);
    settle(2);
    check("dpa_res_bad_key", dpa_res_working, RES_16);
    prev = RES_16;
    for (i = 0; i < 4; i++) begin
      wr(IDX_DPA_RES, 8'(res_code[i]));
      settle(2);
      check("dpa_res_shadowed", dpa_res_working, prev);
      wr(IDX_SWRST, 8'hfa);
      settle(2);
      check("dpa_res_loaded", dpa_res_working, res_code[i]);
      check("dpa_elements", dpa_elements, res_elem[i]);
      check("phase_offset_clip", phase_offset_value, res_clip[i]);
      prev = res_code[i];
    end
    wr(IDX_FILTER, 8'h80);
    settle(2);
    check("phase_offset_zero", phase_offset_value, 32'h0);
    @(posedge aclk);
    lock_pin <= 1'b1;
    for (i = 0; i < 4; i++) begin
      wr(IDX_CTRL, 8'((i << CTRL_SRC_LSB) | 1));
      settle(6);
      check("lockref_src", lockref_out, (i == 1) ? 32'h1 : 32'h0);
    end
    rd(IDX_STATUS);
    check("status_lock", last_data, 32'h2);
    wr(IDX_CTRL, 8'h41);
    @(posedge aclk);
    lock_pin <= 1'b0;
    settle(6);
    check("lockref_unlocked", lockref_out, 32'h0);
    ////////////////////////////////////////////////////////////////////////////////
    wr(IDX_CTRL, 8'hc1);
    for (i = 1; i < 10; i += 4) begin
      wr(IDX_REF, 8'(8'h80 | i));
      measure(1'b0);
      measure(1'b0);
      check("ref_high", hi, P);
      check("ref_low", lo, (i + 1) * P);
      check("ref_next_high", hi2, P);
      measure(1'b1);
      check("pd_high", hi, P);
      check("pd_low", lo, (i + 1) * P);
    end
    wr(IDX_REF, 8'h01);
    @(posedge aclk);
    hs_level <= 1'b1;
    settle(6);
    check("lockref_sync", lockref_out, 32'h1);
    check("pd_sync", phase_detect_in, 32'h1);
    wr(IDX_CTRL, 8'hc5);
    settle(6);
    check("lockref_sync_inv", lockref_out, 32'h0);
    @(posedge aclk);
    hs_level <= 1'b0;
    settle(6);
    check("lockref_sync_low", lockref_out, 32'h1);
    ////////////////////////////////////////////////////////////////////////////////
    // Pump gating: the pin cuts at once, only the second sync rise re-arms
    @(posedge aclk);
    hold_pin <= 1'b0;
    wr(IDX_CTRL, 8'h00);
    settle(2);
    check("pump_held", pump_enable, 32'h0);
    @(posedge aclk);
    hold_pin <= 1'b1;
    settle(6);
    check("pump_unarmed", pump_enable, 32'h0);
    pulse();
    check("pump_one_sync", pump_enable, 32'h0);
    pulse();
    check("pump_rearmed", pump_enable, 32'h1);
    @(posedge aclk);
    hold_pin <= 1'b0;
    #1;
    check("pump_instant_off", pump_enable, 32'h0);
    wr(IDX_CTRL, 8'h02);
    settle(6);
    check("pump_pol_unarmed", pump_enable, 32'h0);
    pulse();
    pulse();
    check("pump_pol_rearmed", pump_enable, 32'h1);
    @(posedge aclk);
    hold_pin <= 1'b1;
    #1;
    check("pump_pol_off", pump_enable, 32'h0);
    wr(IDX_CTRL, 8'h03);
    settle(2);
    check("pump_forced", pump_enable, 32'h1);
    summarize();
  end
endmodule : tb_top
